/* File: verilog/awm_pkg.sv */
package awm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CYC_EN = 8'hE6;
	localparam logic [7:0] IDX_MASK   = 8'hE7;
	localparam logic [7:0] IDX_LO     = 8'hE8;
	localparam logic [7:0] IDX_HI     = 8'hE9;
	localparam logic [7:0] IDX_LP_PRT = 8'hEA;
	localparam logic [7:0] IDX_NR_PRT = 8'hEB;
	localparam logic [7:0] IDX_SHADOW = 8'hEC;
	localparam logic [7:0] IDX_SMI    = 8'hED;
	localparam logic [7:0] IDX_GATE   = 8'hF8;
	localparam logic [7:0] IDX_INIT   = 8'hF9;
	localparam logic [7:0] IDX_STATE  = 8'hFA;
	localparam int         ADDR_W     = 12;
	// Reset values
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_PORT   = 8'h01;
	// Writable bit masks (reserved bits read zero)
	localparam logic [7:0] MASK_WMASK = 8'hEF;
	localparam logic [7:0] GATE_WMASK = 8'hAF;
	// Source bit positions, shared by enable and SMI registers
	localparam int SRC_RANGE = 7;
	localparam int SRC_PAR   = 6;
	localparam int SRC_VIDEO = 5;
	localparam int SRC_HDD   = 4;
	localparam int SRC_FDD   = 3;
	localparam int SRC_KBD   = 2;
	localparam int SRC_SER1  = 1;
	localparam int SRC_SER2  = 0;
	// Wake source register fields
	localparam int MSK_PCIR  = 7;
	localparam int MSK_CLM   = 6;
	localparam int MSK_EXT   = 5;
	localparam int MSK_TYPE  = 3;
	// Gate register fields
	localparam int GT_SMI_A  = 7;
	localparam int GT_SMI_B  = 5;
	localparam int GT_HWSTB  = 3;
	localparam int GT_STB_LP = 2;
	localparam int GT_STB_WK = 1;
	localparam int GT_PREQWK = 0;
	// Decoded address ranges
	localparam logic [15:0] PAR1_LO = 16'h0378;
	localparam logic [15:0] PAR1_HI = 16'h037F;
	localparam logic [15:0] PAR2_LO = 16'h0278;
	localparam logic [15:0] PAR2_HI = 16'h027F;
	localparam logic [31:0] VMEM_LO = 32'h000A_0000;
	localparam logic [31:0] VMEM_HI = 32'h000B_FFFF;
	localparam logic [15:0] VIO_LO  = 16'h03B0;
	localparam logic [15:0] VIO_HI  = 16'h03DF;
	localparam logic [15:0] HD1_LO  = 16'h0170;
	localparam logic [15:0] HD1_HI  = 16'h0177;
	localparam logic [15:0] HD1_AUX = 16'h0376;
	localparam logic [15:0] HD2_LO  = 16'h01F0;
	localparam logic [15:0] HD2_HI  = 16'h01F7;
	localparam logic [15:0] HD2_AUX = 16'h03F6;
	localparam logic [15:0] FDD_DAT = 16'h03F5;
	localparam logic [15:0] KBD_DAT = 16'h0060;
	localparam logic [15:0] KBD_CMD = 16'h0064;
	localparam logic [15:0] SA1_LO  = 16'h03F8;
	localparam logic [15:0] SA1_HI  = 16'h03FF;
	localparam logic [15:0] SA2_LO  = 16'h03E8;
	localparam logic [15:0] SA2_HI  = 16'h03EF;
	localparam logic [15:0] SB1_LO  = 16'h02F8;
	localparam logic [15:0] SB1_HI  = 16'h02FF;
	localparam logic [15:0] SB2_LO  = 16'h02E8;
	localparam logic [15:0] SB2_HI  = 16'h02EF;
endpackage : awm_pkg

/* File: verilog/awm_monitor.sv */
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ns
module awm_monitor
	import awm_pkg::*;
(
	input  wire logic              I_CLK,
	input  wire logic              I_RESETN,
	input  wire logic              I_PSEL,
	input  wire logic              I_PENABLE,
	input  wire logic              I_PWRITE,
	input  wire logic [ADDR_W-1:0] I_PADDR,
	input  wire logic [31:0]       I_PWDATA,
	output logic      [31:0]       O_PRDATA,
	output logic                   O_PREADY,
	output logic                   O_PSLVERR,
	input  wire logic              I_CYC_VALID,
	input  wire logic              I_CYC_IS_MEM,
	input  wire logic [31:0]       I_CYC_ADDR,
	input  wire logic              I_PCI_REQUEST_LINE_N,
	input  wire logic              I_LOCAL_DEVICE_CLAIM_N,
	input  wire logic              I_EXT_PM_INTERRUPT_IN,
	input  wire logic              I_IDLE_TICK,
	output logic                   O_RELOAD,
	output logic                   O_WAKE,
	output logic                   O_IDLE_TIMEOUT,
	output logic                   O_LOW_POWER_STATE,
	output logic                   O_SYS_MGMT_INTERRUPT_N,
	output logic                   O_POWER_LATCH_STROBE_N,
	output logic      [7:0]        O_POWER_LATCH_DATA
);

////////////////////////////////////////////////////////////////////////
// Helpers

// Inclusive I/O range test
function automatic logic in_rng(input logic [15:0] a,
	input logic [15:0] lo, input logic [15:0] hi);
	return (a >= lo) && (a <= hi);
endfunction : in_rng

// Low byte compare with the lowest n bits ignored
function automatic logic low_hit(input logic [7:0] a,
	input logic [7:0] r, input logic [2:0] n);
	logic [7:0] keep;
	keep = 8'hFF << n;
	return ((a ^ r) & keep) == 8'h00;
endfunction : low_hit

// Register select on an aligned word
function automatic logic sel(input logic [ADDR_W-1:0] a,
	input logic [7:0] idx);
	return a == {2'b00, idx, 2'b00};
endfunction : sel

////////////////////////////////////////////////////////////////////////
// Registers and state

logic [7:0] cyc_en_q;     // Access detection enables
logic [7:0] mask_q;       // Wake sources, type, mask code
logic [7:0] lo_q;         // Range low byte
logic [7:0] hi_q;         // Range high byte
logic [7:0] lp_prt_q;     // Low-power port byte
logic [7:0] nr_prt_q;     // Normal port byte
logic [7:0] shadow_q;     // Mirror of external latch
logic [7:0] smi_en_q;     // SMI enables
logic [7:0] smi_flag_q;   // Sticky SMI causes
logic [7:0] gate_q;       // Global gating and strobe enables
logic [7:0] init_q;       // Idle timer initial count
logic [7:0] cnt_q;        // Idle timer current count
logic       lp_q;         // Low-power state
logic       req_m_q;      // Sync first stage
logic       req_s_q;      // Sync second stage
logic       clm_m_q;      // Sync first stage
logic       clm_s_q;      // Sync second stage
logic       pready_q;
logic       pslverr_q;
logic [31:0] prdata_q;
logic       reload_q;
logic       wake_q;
logic       tmo_q;
logic       smi_n_q;
logic       stb_n_q;

// Bus strobes
logic setup;
logic wr;
logic wr_shadow;
logic wr_smi;
assign setup     = I_PSEL && !I_PENABLE;
assign wr        = I_PSEL && I_PENABLE && I_PWRITE && pready_q;
assign wr_shadow = wr && sel(I_PADDR, IDX_SHADOW);
assign wr_smi    = wr && sel(I_PADDR, IDX_SMI);

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

// Request and claim pins come from other clocks
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		req_m_q <= 1'b1;
		req_s_q <= 1'b1;
		clm_m_q <= 1'b1;
		clm_s_q <= 1'b1;
	end else begin
		req_m_q <= I_PCI_REQUEST_LINE_N;
		req_s_q <= req_m_q;
		clm_m_q <= I_LOCAL_DEVICE_CLAIM_N;
		clm_s_q <= clm_m_q;
	end
end

////////////////////////////////////////////////////////////////////////
// Cycle decode

logic       io_c;        // I/O cycle
logic       mem_c;       // Memory cycle
logic [15:0] ioa;        // I/O address
logic       rng_io;      // Range hit as I/O
logic       rng_mem;     // Range hit as memory
logic [7:0] hit;         // Per-source hits
logic       acc_ev;      // Enabled access event
logic       src_reload;  // Any reload cause
logic       src_wake;    // Any wake cause
logic [7:0] smi_set;     // SMI causes this cycle
logic       reload_d;
logic       wake_d;
logic       sleep_d;

assign io_c  = I_CYC_VALID && !I_CYC_IS_MEM;
assign mem_c = I_CYC_VALID && I_CYC_IS_MEM;
assign ioa   = I_CYC_ADDR[15:0];

// Unmasked bits of both bytes must all agree
assign rng_io  = io_c && low_hit(I_CYC_ADDR[7:0], lo_q, mask_q[2:0])
	&& (I_CYC_ADDR[15:8] == hi_q);
assign rng_mem = mem_c && low_hit(I_CYC_ADDR[23:16], lo_q, mask_q[2:0])
	&& (I_CYC_ADDR[31:24] == hi_q);

// Source hits, independent of enables
always_comb begin
	hit = 8'h00;
	hit[SRC_RANGE] = mask_q[MSK_TYPE] ? rng_mem : rng_io;
	hit[SRC_PAR]   = io_c && (in_rng(ioa, PAR1_LO, PAR1_HI)
		|| in_rng(ioa, PAR2_LO, PAR2_HI));
	hit[SRC_VIDEO] = (io_c && in_rng(ioa, VIO_LO, VIO_HI))
		|| (mem_c && I_CYC_ADDR >= VMEM_LO && I_CYC_ADDR <= VMEM_HI);
	hit[SRC_HDD]   = io_c && (in_rng(ioa, HD1_LO, HD1_HI) || ioa == HD1_AUX
		|| in_rng(ioa, HD2_LO, HD2_HI) || ioa == HD2_AUX);
	hit[SRC_FDD]   = io_c && (ioa == FDD_DAT);
	hit[SRC_KBD]   = io_c && (ioa == KBD_DAT || ioa == KBD_CMD);
	hit[SRC_SER1]  = io_c && (in_rng(ioa, SA1_LO, SA1_HI)
		|| in_rng(ioa, SA2_LO, SA2_HI));
	hit[SRC_SER2]  = io_c && (in_rng(ioa, SB1_LO, SB1_HI)
		|| in_rng(ioa, SB2_LO, SB2_HI));
end

// Enabled accesses; a cleared bit drops its source
assign acc_ev = |(hit & cyc_en_q);

// Reload causes; request line reloads with its detect bit alone
assign src_reload = acc_ev
	|| (!req_s_q && mask_q[MSK_PCIR])
	|| (!clm_s_q && mask_q[MSK_CLM])
	|| (I_EXT_PM_INTERRUPT_IN && mask_q[MSK_EXT]);

// Wake causes; request wakes only with companion enable
assign src_wake = acc_ev
	|| (!req_s_q && mask_q[MSK_PCIR] && gate_q[GT_PREQWK])
	|| (!clm_s_q && mask_q[MSK_CLM])
	|| (I_EXT_PM_INTERRUPT_IN && mask_q[MSK_EXT])
	|| (|(hit & smi_en_q));

// SMI needs both global bits
assign smi_set = hit & smi_en_q & {8{gate_q[GT_SMI_A] && gate_q[GT_SMI_B]}};

// In normal state activity reloads; in low power it wakes
assign reload_d = !lp_q && src_reload;
assign wake_d   = lp_q && src_wake;
assign sleep_d  = !lp_q && !reload_d && I_IDLE_TICK && (cnt_q == 8'h01);

////////////////////////////////////////////////////////////////////////
// Idle timer and power state

// Restart on any activity; zero count parks the timer
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		cnt_q <= RST_ZERO;
	end else if (reload_d || wake_d) begin
		cnt_q <= init_q;
	end else if (I_IDLE_TICK && !lp_q && cnt_q != 8'h00) begin
		cnt_q <= cnt_q - 8'h01;
	end
end

// Timeout enters low power, a wake leaves it
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		lp_q <= 1'b0;
	end else if (sleep_d) begin
		lp_q <= 1'b1;
	end else if (wake_d) begin
		lp_q <= 1'b0;
	end
end

// Event pulses
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		reload_q <= 1'b0;
		wake_q   <= 1'b0;
		tmo_q    <= 1'b0;
	end else begin
		reload_q <= reload_d;
		wake_q   <= wake_d;
		tmo_q    <= sleep_d;
	end
end

////////////////////////////////////////////////////////////////////////
// Power latch shadow and strobe

logic hw_lp;
logic hw_wk;
assign hw_lp = sleep_d && gate_q[GT_HWSTB] && gate_q[GT_STB_LP];
assign hw_wk = wake_d && gate_q[GT_HWSTB] && gate_q[GT_STB_WK];

// Software write wins over a hardware load in the same cycle
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		shadow_q <= RST_PORT;
		stb_n_q  <= 1'b1;
	end else begin
		stb_n_q <= !(wr_shadow || hw_lp || hw_wk);
		if (wr_shadow) begin
			shadow_q <= I_PWDATA[7:0];
		end else if (hw_lp) begin
			shadow_q <= lp_prt_q;
		end else if (hw_wk) begin
			shadow_q <= nr_prt_q;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// SMI enables and sticky causes

// New cause wins over a clear; a written 0 still hides it
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		smi_en_q   <= RST_ZERO;
		smi_flag_q <= RST_ZERO;
		smi_n_q    <= 1'b1;
	end else begin
		if (wr_smi) begin
			smi_en_q   <= I_PWDATA[7:0];
			smi_flag_q <= smi_set | (smi_flag_q & I_PWDATA[7:0]);
		end else begin
			smi_flag_q <= smi_set | smi_flag_q;
		end
		smi_n_q <= !(|(smi_flag_q & smi_en_q));
	end
end

////////////////////////////////////////////////////////////////////////
// Configuration registers

// Reserved bits are not stored
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		cyc_en_q <= RST_ZERO;
		mask_q   <= RST_ZERO;
		lo_q     <= RST_ZERO;
		hi_q     <= RST_ZERO;
		lp_prt_q <= RST_PORT;
		nr_prt_q <= RST_PORT;
		gate_q   <= RST_ZERO;
		init_q   <= RST_ZERO;
	end else if (wr) begin
		if (sel(I_PADDR, IDX_CYC_EN)) cyc_en_q <= I_PWDATA[7:0];
		if (sel(I_PADDR, IDX_MASK))   mask_q   <= I_PWDATA[7:0] & MASK_WMASK;
		if (sel(I_PADDR, IDX_LO))     lo_q     <= I_PWDATA[7:0];
		if (sel(I_PADDR, IDX_HI))     hi_q     <= I_PWDATA[7:0];
		if (sel(I_PADDR, IDX_LP_PRT)) lp_prt_q <= I_PWDATA[7:0];
		if (sel(I_PADDR, IDX_NR_PRT)) nr_prt_q <= I_PWDATA[7:0];
		if (sel(I_PADDR, IDX_GATE))   gate_q   <= I_PWDATA[7:0] & GATE_WMASK;
		if (sel(I_PADDR, IDX_INIT))   init_q   <= I_PWDATA[7:0];
	end
end

////////////////////////////////////////////////////////////////////////
// APB read path, answered in the access phase

logic [7:0] rd_val;
logic       rd_ok;
always_comb begin
	rd_val = 8'h00;
	rd_ok  = (I_PADDR[ADDR_W-1:ADDR_W-2] == 2'b00) && (I_PADDR[1:0] == 2'b00);
	case (I_PADDR[9:2])
		IDX_CYC_EN: rd_val = cyc_en_q;
		IDX_MASK:   rd_val = mask_q;
		IDX_LO:     rd_val = lo_q;
		IDX_HI:     rd_val = hi_q;
		IDX_LP_PRT: rd_val = lp_prt_q;
		IDX_NR_PRT: rd_val = nr_prt_q;
		IDX_SHADOW: rd_val = shadow_q;
		IDX_SMI:    rd_val = smi_flag_q & smi_en_q;
		IDX_GATE:   rd_val = gate_q;
		IDX_INIT:   rd_val = init_q;
		IDX_STATE:  rd_val = {cnt_q[6:0], lp_q};
		default:    rd_ok  = 1'b0; // Unmapped answers with an error
	endcase
end

// Ready and data registered from the setup cycle
always_ff @(posedge I_CLK) begin
	if (!I_RESETN) begin
		pready_q  <= 1'b0;
		pslverr_q <= 1'b0;
		prdata_q  <= 32'h0000_0000;
	end else begin
		pready_q  <= setup;
		pslverr_q <= setup && !rd_ok;
		if (setup) begin
			prdata_q <= rd_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Outputs

assign O_PRDATA               = prdata_q;
assign O_PREADY               = pready_q;
assign O_PSLVERR              = pslverr_q;
assign O_RELOAD               = reload_q;
assign O_WAKE                 = wake_q;
assign O_IDLE_TIMEOUT         = tmo_q;
assign O_LOW_POWER_STATE      = lp_q;
assign O_SYS_MGMT_INTERRUPT_N = smi_n_q;
assign O_POWER_LATCH_STROBE_N = stb_n_q;
assign O_POWER_LATCH_DATA     = shadow_q;

////////////////////////////////////////////////////////////////////////
// Assertions

default clocking cb @(posedge I_CLK); endclocking
default disable iff (!I_RESETN);

a_range_io_reload: assert property (
	(io_c && cyc_en_q[SRC_RANGE] && !mask_q[MSK_TYPE] && !lp_q
	&& I_CYC_ADDR[15:0] == {hi_q, lo_q}) |=> O_RELOAD)
	else $error("range I/O access gave no reload");

a_par_reload: assert property (
	(io_c && ioa == PAR2_HI && cyc_en_q[SRC_PAR] && !lp_q) |=> O_RELOAD)
	else $error("parallel port access gave no reload");

a_video_mem: assert property (
	(mem_c && I_CYC_ADDR == VMEM_HI && cyc_en_q[SRC_VIDEO] && !lp_q) |=> O_RELOAD)
	else $error("video memory access gave no reload");

a_kbd_wake: assert property (
	(io_c && ioa == KBD_CMD && cyc_en_q[SRC_KBD] && lp_q) |=> O_WAKE && !lp_q)
	else $error("keyboard access did not wake");

a_mask_seven: assert property (
	(io_c && mask_q[2:0] == 3'h7 && !mask_q[MSK_TYPE] && cyc_en_q[SRC_RANGE]
	&& !lp_q && I_CYC_ADDR[15:7] == {hi_q, lo_q[7]}) |=> O_RELOAD)
	else $error("masked range access gave no reload");

a_mem_range: assert property (
	(mem_c && mask_q[MSK_TYPE] && mask_q[2:0] == 3'h0 && cyc_en_q[SRC_RANGE]
	&& !lp_q && I_CYC_ADDR[31:16] == {hi_q, lo_q}) |=> O_RELOAD)
	else $error("memory range access gave no reload");

a_all_quiet: assert property (
	(cyc_en_q == 8'h00 && mask_q[7:5] == 3'h0 && smi_en_q == 8'h00)
	|=> !O_RELOAD && !O_WAKE)
	else $error("event with every source disabled");

a_sw_strobe: assert property (
	wr_shadow |=> !O_POWER_LATCH_STROBE_N
	&& O_POWER_LATCH_DATA == $past(I_PWDATA[7:0]))
	else $error("shadow write did not strobe its value");

a_lp_latch: assert property (
	(hw_lp && !wr_shadow) |=> O_POWER_LATCH_DATA == $past(lp_prt_q)
	&& O_LOW_POWER_STATE ##1 O_POWER_LATCH_STROBE_N)
	else $error("low-power entry loaded wrong byte");

a_strobe_off: assert property (
	(!gate_q[GT_HWSTB] && !wr_shadow) |=> O_POWER_LATCH_STROBE_N)
	else $error("hardware strobe while disabled");

a_smi_raise: assert property (
	(|smi_set && !wr_smi) |=> ##1 !O_SYS_MGMT_INTERRUPT_N)
	else $error("gated cause raised no interrupt");

a_smi_clear: assert property (
	(wr_smi && I_PWDATA[7:0] == 8'h00) |=> ##1 O_SYS_MGMT_INTERRUPT_N)
	else $error("zero write left interrupt asserted");

a_timer_restart: assert property (
	reload_d |=> cnt_q == $past(init_q))
	else $error("idle timer not restarted");

c_idle_timeout: cover property (O_IDLE_TIMEOUT ##[1:20] O_WAKE);
c_smi_raised: cover property ($fell(O_SYS_MGMT_INTERRUPT_N));
c_hw_strobe: cover property (hw_wk ##1 !O_POWER_LATCH_STROBE_N);

endmodule : awm_monitor

/* File: verif/awm_far_latch.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////
// Board-level power control latch that sits behind the strobe pin
module awm_far_latch
	import awm_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_strobe_n,
	input  wire logic [7:0] i_data,
	output logic      [7:0] o_latched
);
	// Power-on content taken equal to the shadow reset value
	initial o_latched = RST_PORT;
	// Captures only while strobe is low; a stuck-high strobe leaves stale data
	always @(posedge i_clk) begin
		if (i_strobe_n === 1'b0) begin
			o_latched <= i_data;
		end
	end
endmodule : awm_far_latch

/* File: verif/test_activity_wakeup_monitor.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////
// Self-checking bench: drivers note results, one watcher compares them
module test_activity_wakeup_monitor;
	import awm_pkg::*;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic        cyc_v, cyc_mem, pcireq_n, claim_n, ext_pm, tick;
	logic        reload, wake, tout, lowp, smi_n, stb_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, cyc_addr, seed;
	logic [7:0]  ldata, latched;
	logic [32:0] q_rd[$], q_ev[$], q_stb[$];
	logic [31:0] hit_tab[16], miss_tab[11], r;
	int          error_cnt, n_compared, cycles, n_tmo;
	//////////////////////////////////////////////////////////////////
	// Design and far-side latch
	awm_monitor dut_u (.I_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_CYC_VALID(cyc_v), .I_CYC_IS_MEM(cyc_mem),
		.I_CYC_ADDR(cyc_addr), .I_PCI_REQUEST_LINE_N(pcireq_n), .I_LOCAL_DEVICE_CLAIM_N(claim_n),
		.I_EXT_PM_INTERRUPT_IN(ext_pm), .I_IDLE_TICK(tick), .O_RELOAD(reload), .O_WAKE(wake),
		.O_IDLE_TIMEOUT(tout), .O_LOW_POWER_STATE(lowp), .O_SYS_MGMT_INTERRUPT_N(smi_n),
		.O_POWER_LATCH_STROBE_N(stb_n), .O_POWER_LATCH_DATA(ldata));
	awm_far_latch far_u (.i_clk(clk), .i_strobe_n(stb_n), .i_data(ldata), .o_latched(latched));
	//////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// One comparison, counted; a mismatch is reported at once
	function automatic void chk(string nm, logic [32:0] e, logic [32:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endfunction : chk
	task automatic close_out();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out
	// APB transfer; entered just after an edge, leaves one idle cycle
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		// Wait for ready however long; only the hang guard ends a stuck wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr
	// Read with expected data and error flag noted first
	task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic err);
		q_rd.push_back({err, 24'h00_0000, e});
		apb(1'b0, idx, 8'h00);
	endtask : rd
	// One decoded host cycle; ev is the expected {wake, reload}
	task automatic cyc(input logic [31:0] a, input logic [1:0] ev);
		if (ev != 2'b00) q_ev.push_back({31'h0000_0000, ev});
		cyc_v    <= 1'b1;
		cyc_mem  <= |a[31:16];
		cyc_addr <= a;
		@(posedge clk);
		cyc_v    <= 1'b0;
		@(posedge clk);
	endtask : cyc
	// Bounded wait on the interrupt level, then compare
	task automatic wait_smi(input logic v);
		int n;
		n = 0;
		while (smi_n !== v && n < 6) begin
			@(posedge clk);
			n++;
		end
		chk("smi_n", {32'h0000_0000, v}, {32'h0000_0000, smi_n});
	endtask : wait_smi
	//////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// Watcher: every result that shows takes the oldest note of its kind
	always @(posedge clk) begin
		if (rstn === 1'b1) begin
			if (psel && penable && !pwrite && pready === 1'b1)
				chk("prdata", q_rd.size() ? q_rd.pop_front() : 33'bx, {pslverr, prdata});
			if (reload === 1'b1 || wake === 1'b1)
				chk("event", q_ev.size() ? q_ev.pop_front() : 33'bx, {31'h0, wake, reload});
			if (stb_n === 1'b0)
				chk("latch_data", q_stb.size() ? q_stb.pop_front() : 33'bx, {25'h0, ldata});
			// Timeout pulses are counted and checked at the end
			if (tout === 1'b1) n_tmo++;
		end
	end
	//////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rstn, psel, penable, pwrite, cyc_v, cyc_mem, ext_pm, tick} = 8'h00;
		{pcireq_n, claim_n} = 2'b11;
		{paddr, pwdata, cyc_addr} = '0;
		{error_cnt, n_compared, cycles, n_tmo} = '0;
		seed = 32'h0000_0044;
		// Hits per source bit, two each; bit 7 is the range 1234h
		hit_tab = '{32'h0000_02F8, 32'h0000_02EF, 32'h0000_03FF, 32'h0000_03E8,
			32'h0000_0060, 32'h0000_0064, 32'h0000_03F5, 32'h0000_03F5,
			32'h0000_0177, 32'h0000_03F6, 32'h000B_FFFF, 32'h0000_03B0,
			32'h0000_0378, 32'h0000_027F, 32'h0000_1234, 32'h0000_1234};
		// Neighbours just outside the parallel, video, serial, keyboard and range decodes
		miss_tab = '{32'h0000_0380, 32'h0000_0277, 32'h0000_03AF, 32'h0000_03E0,
			32'h0000_03E7, 32'h0000_02F7, 32'h0000_0061, 32'h0000_0063,
			32'h000C_0000, 32'h0009_FFFF, 32'h0000_1235};
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		// Reset values, then an unmapped index
		for (int i = 0; i < 8; i++) rd(8'hE6 + i[7:0], (i >= 4 && i <= 6) ? 8'h01 : 8'h00, 1'b0);
		rd(8'h10, 8'h00, 1'b1);
		// Each source alone sees only its own ranges
		wr(8'hE8, 8'h34);
		wr(8'hE9, 8'h12);
		wr(8'hE7, 8'h00);
		for (int b = 0; b < 8; b++) begin
			wr(8'hE6, 8'h01 << b);
			for (int j = 0; j < 16; j++) cyc(hit_tab[j], {1'b0, j / 2 == b});
		end
		wr(8'hE6, 8'hFF);
		for (int j = 0; j < 11; j++) cyc(miss_tab[j], 2'b00);
		wr(8'hE6, 8'h00);
		for (int j = 0; j < 16; j++) cyc(hit_tab[j], 2'b00);
		// Memory range with a random mask code
		wr(8'hE8, 8'h5A);
		wr(8'hE9, 8'hC3);
		wr(8'hE6, 8'h80);
		for (int k = 0; k < 8; k++) begin
			r = xs();
			wr(8'hE7, {5'b00001, r[2:0]});
			cyc({8'hC3, 8'h5A ^ (r[10:3] & ((8'h01 << r[2:0]) - 8'h01)), r[31:16]}, 2'b01);
			cyc({8'hC3, 8'h5A ^ (8'h01 << r[2:0]), r[31:16]}, 2'b00);
			cyc({8'hC2, 8'h5A, r[31:16]}, 2'b00);
			cyc(32'h0000_C35A, 2'b00);
		end
		// I/O range with all low bits but A7 ignored, then memory with none
		wr(8'hE7, 8'h07);
		cyc({16'h0000, 8'hC3, 1'b0, r[6:0]}, 2'b01);
		cyc(32'h0000_C3DA, 2'b00);
		wr(8'hE7, 8'h08);
		cyc({8'hC3, 8'h5A, r[15:0]}, 2'b01);
		// Request, claim and external interrupt pins, enabled then disabled
		for (int e = 0; e < 2; e++) begin
			wr(8'hE7, e ? 8'h00 : 8'hE0);
			for (int p = 0; p < 3; p++) begin
				if (e == 0) q_ev.push_back(33'h0_0000_0001);
				pcireq_n <= (p != 0);
				claim_n  <= (p != 1);
				ext_pm   <= (p == 2);
				@(posedge clk);
				{pcireq_n, claim_n, ext_pm} <= 3'b110;
				repeat (6) @(posedge clk);
			end
		end
		// Timeout into low power and wake, without and with the strobe
		wr(8'hE7, 8'h00);
		wr(8'hEA, 8'h5C);
		wr(8'hEB, 8'h3A);
		wr(8'hF9, 8'h02);
		wr(8'hE6, 8'h04);
		for (int g = 0; g < 2; g++) begin
			wr(8'hF8, g ? 8'h0E : 8'h06);
			cyc(32'h0000_0060, 2'b01);
			if (g) q_stb.push_back(33'h0_0000_005C);
			for (int n = 0; n < 40 && lowp !== 1'b1; n++) begin
				tick <= 1'b1;
				@(posedge clk);
			end
			tick <= 1'b0;
			chk("low_power", 33'h1, {32'h0, lowp});
			if (g) q_stb.push_back(33'h0_0000_003A);
			cyc(32'h0000_0064, 2'b10);
			repeat (3) @(posedge clk);
			chk("low_power", 33'h0, {32'h0, lowp});
		end
		// Software shadow write strobes the latch
		q_stb.push_back(33'h0_0000_00A5);
		wr(8'hEC, 8'hA5);
		rd(8'hEC, 8'hA5, 1'b0);
		// Interrupt sources 4..7, sticky flag and clear
		wr(8'hE8, 8'h34);
		wr(8'hE9, 8'h12);
		wr(8'hF8, 8'hA0);
		for (int b = 4; b < 8; b++) begin
			wr(8'hE6, 8'h01 << b);
			wr(8'hED, 8'h01 << b);
			cyc(hit_tab[2 * b], 2'b01);
			wait_smi(1'b0);
			rd(8'hED, 8'h01 << b, 1'b0);
			wr(8'hED, 8'h00);
			wait_smi(1'b1);
			rd(8'hED, 8'h00, 1'b0);
		end
		// One global enable missing keeps the interrupt quiet
		wr(8'hF8, 8'h80);
		wr(8'hED, 8'h80);
		cyc(32'h0000_1234, 2'b01);
		repeat (4) @(posedge clk);
		chk("smi_n", 33'h1, {32'h0, smi_n});
		chk("pending", 33'h0, 33'(q_rd.size() + q_ev.size() + q_stb.size()));
		chk("far_latch", 33'h0_0000_00A5, {25'h0, latched});
		chk("timeouts", 33'h2, 33'(n_tmo));
		close_out();
	end
endmodule : test_activity_wakeup_monitor
